/* File: dbgrs_host_model.sv */
// Purpose: debug host tally of words left to drain from the fifo, one less per pop
// Assumes: loaded with the captured valid count
// Notes: never counts below zero
`timescale 1ns/100ps
module dbgrs_host_model (
  input logic i_clock,
  input logic i_load,
  input logic [3:0] i_count,
  input logic i_pop,
  output logic [3:0] o_tally
);
  always_ff @(posedge i_clock) begin
    if (i_load) begin
      o_tally <= i_count;
    end else if (i_pop && o_tally != 4'h0) begin
      o_tally <= o_tally - 4'h1;
    end
  end
endmodule : dbgrs_host_model

/* File: dbgrs_pkg.sv */
// Purpose: shared constants of the debug run status tracker
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: offsets are byte addresses
package dbgrs_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] DBGRS_OFS_CTRL = 8'h00;
  localparam logic [7:0] DBGRS_OFS_STATUS = 8'h04;
  localparam logic [7:0] DBGRS_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] DBGRS_OFS_IRQ_MASK = 8'h0c;
  // ==========================================================
  // debug_control_reg fields
  localparam int DBGRS_CTRL_ENABLE = 7;
  localparam int DBGRS_CTRL_ARM = 6;
  localparam int DBGRS_CTRL_BEGIN = 5;
  // ==========================================================
  // debug_run_status fields
  localparam int DBGRS_ST_MATCH_A = 7;
  localparam int DBGRS_ST_MATCH_B = 6;
  localparam int DBGRS_ST_ARMED = 5;
  localparam int DBGRS_ST_CNT_LSB = 0;
  // ==========================================================
  // interrupt status and mask fields
  localparam int DBGRS_IRQ_RUN_END = 0;
  localparam int DBGRS_IRQ_MATCH_A = 1;
  localparam int DBGRS_IRQ_MATCH_B = 2;
  localparam int DBGRS_IRQ_W = 3;
  // ==========================================================
  // fifo count and reset values
  localparam int DBGRS_CNT_W = 4;
  localparam logic [3:0] DBGRS_FIFO_DEPTH = 4'h8;
  localparam logic [3:0] DBGRS_CNT_RESET = 4'h0;
  localparam logic [2:0] DBGRS_IRQ_RESET = 3'h0;
  localparam logic [31:0] DBGRS_RDATA_RESET = 32'h0000_0000;
  // ==========================================================
  // ahb encodings
  localparam logic [1:0] DBGRS_HTRANS_NONSEQ = 2'h2;
  localparam logic DBGRS_HRESP_OKAY = 1'h0;
endpackage : dbgrs_pkg

/* File: dbgrs_run_core.sv */
// Purpose: tracks one debug run: armed state, match flags, fifo valid count
// Assumes: start only when not armed; stop only when armed
// Notes: flags and count hold after the run until the next start
`timescale 1ns/100ps
module dbgrs_run_core
  import dbgrs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  dbgrs_run_if.core run
);
  typedef struct packed {
    logic armed;
    logic flag_a;
    logic flag_b;
    logic [DBGRS_CNT_W-1:0] count;
    logic start_p;
    logic end_p;
    logic set_a_p;
    logic set_b_p;
  } dbgrs_core_s;

  dbgrs_core_s state;
  dbgrs_core_s next_state;
  logic auto_end;
  logic [DBGRS_CNT_W-1:0] clamped;

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    next_state.start_p = 1'b0;
    next_state.end_p = 1'b0;
    next_state.set_a_p = 1'b0;
    next_state.set_b_p = 1'b0;
    clamped = (run.fifo_count > DBGRS_FIFO_DEPTH) ? DBGRS_FIFO_DEPTH : run.fifo_count; // RULE8
    // begin trace ends on full, end trace on trigger
    auto_end = run.begin_trace ? run.fifo_full : run.trigger; // RULE12
    if (run.start) begin
      next_state.armed = 1'b1; // RULE4
      next_state.flag_a = 1'b0; // RULE1
      next_state.flag_b = 1'b0; // RULE2
      next_state.count = DBGRS_CNT_RESET; // RULE7
      next_state.start_p = 1'b1;
    end else if (state.armed) begin // RULE9 RULE13
      next_state.count = clamped; // RULE7
      if (run.match_a && !state.flag_a) begin
        next_state.flag_a = 1'b1; // RULE1
        next_state.set_a_p = 1'b1;
      end
      if (run.match_b && !state.flag_b) begin
        next_state.flag_b = 1'b1; // RULE2
        next_state.set_b_p = 1'b1;
      end
      if (run.stop || auto_end) begin
        next_state.armed = 1'b0; // RULE5 RULE6
        next_state.end_p = 1'b1;
      end
    end
    // outside a run flags and count hold
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign run.armed = state.armed;
  assign run.match_a_flag = state.flag_a;
  assign run.match_b_flag = state.flag_b;
  assign run.fifo_valid_count = state.count;
  assign run.run_start = state.start_p;
  assign run.run_end = state.end_p;
  assign run.set_a = state.set_a_p;
  assign run.set_b = state.set_b_p;
endmodule : dbgrs_run_core

/* File: dbgrs_run_if.sv */
// Purpose: carries run control and run status between the bus top and the run core
// Assumes: one clock domain
// Notes: all signals are same-clock
`timescale 1ns/100ps
interface dbgrs_run_if;
  import dbgrs_pkg::*;
  logic start;
  logic stop;
  logic begin_trace;
  logic match_a;
  logic match_b;
  logic trigger;
  logic fifo_full;
  logic [DBGRS_CNT_W-1:0] fifo_count;
  logic armed;
  logic match_a_flag;
  logic match_b_flag;
  logic [DBGRS_CNT_W-1:0] fifo_valid_count;
  logic run_start;
  logic run_end;
  logic set_a;
  logic set_b;
  modport top (
    output start, stop, begin_trace, match_a, match_b, trigger, fifo_full, fifo_count,
    input armed, match_a_flag, match_b_flag, fifo_valid_count, run_start, run_end,
    input set_a, set_b
  );
  modport core (
    input start, stop, begin_trace, match_a, match_b, trigger, fifo_full, fifo_count,
    output armed, match_a_flag, match_b_flag, fifo_valid_count, run_start, run_end,
    output set_a, set_b
  );
endinterface : dbgrs_run_if

/* File: dbgrs_sva.sv */
// Purpose: run control checker for dbgrs_top
// Assumes: one clock, synchronous reset
// Notes: bound to every dbgrs_top
`timescale 1ns/100ps
module dbgrs_sva
  import dbgrs_pkg::*;
(
  input logic i_clock,
  input logic i_reset,
  input logic i_hsel,
  input logic [1:0] i_htrans,
  input logic i_hwrite,
  input logic i_hready,
  input logic i_trigger,
  input logic i_fifo_full,
  input logic o_debug_module_enable,
  input logic o_armed,
  input logic o_begin_trace,
  input logic o_run_start,
  input logic o_run_end,
  input logic o_irq
);
  // ==========================================================
  // helpers
  logic wr;
  assign wr = i_hsel && (i_htrans == DBGRS_HTRANS_NONSEQ) && i_hwrite && i_hready;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // assertions
  a_end_full: assert property (o_armed && o_begin_trace && i_fifo_full |=> !o_armed && o_run_end)
    else $error("begin trace run not ended by full fifo");
  a_end_trigger: assert property (o_armed && !o_begin_trace && i_trigger |=> !o_armed && o_run_end)
    else $error("end trace run not ended by trigger");
  a_run_holds: assert property (o_armed && !(o_begin_trace ? i_fifo_full : i_trigger) && !$past(wr) |=> o_armed)
    else $error("run ended without cause");
  a_start_pulse: assert property ($rose(o_armed) |-> o_run_start)
    else $error("arming without start pulse");
  a_end_pulse: assert property ($fell(o_armed) |-> o_run_end)
    else $error("run stop without end pulse");
  a_arm_enabled: assert property (o_armed |-> o_debug_module_enable)
    else $error("armed while module disabled");
  a_mode_stable: assert property (o_armed && $past(o_armed) |-> $stable(o_begin_trace))
    else $error("trace mode changed during run");
  a_end_single: assert property (o_run_end |=> !o_run_end)
    else $error("end pulse longer than one cycle");
  c_start: cover property (o_run_start);
  c_end_begin: cover property (o_run_end && o_begin_trace);
  c_irq: cover property ($rose(o_irq));
endmodule : dbgrs_sva

bind dbgrs_top dbgrs_sva dbgrs_sva_inst (.i_clock(i_clock), .i_reset(i_reset), .i_hsel(i_hsel),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .i_trigger(i_trigger),
  .i_fifo_full(i_fifo_full), .o_debug_module_enable(o_debug_module_enable),
  .o_armed(o_armed), .o_begin_trace(o_begin_trace), .o_run_start(o_run_start),
  .o_run_end(o_run_end), .o_irq(o_irq));

/* File: dbgrs_top.sv */
// Purpose: debug run status tracker with an AHB-Lite register slave
// Assumes: match, trigger, fifo full and fifo count come from logic on i_clock
// Notes: reads take one wait state, writes none; response is always OKAY
//
// Behaviour
// RULE1: match A flag clears at run start, sets on comparator A match.
// RULE2: match B flag clears at run start, sets on comparator B match.
// RULE3: armed status mirrors arm bit while enabled; software cannot write it.
// RULE4: writing arm 1 while enabled arms and starts a new run.
// RULE5: run ends itself: fifo full in begin trace, trigger in end trace.
// RULE6: writing 0 to arm or enable ends the run at once.
// RULE7: valid count clears at run start, holds word count at run end.
// RULE8: valid count is plain binary, 0 up to 8 words.
// RULE9: valid count does not drop as the host drains the fifo.
// RULE10: debug host keeps its own tally of words unloaded.
// RULE11: status register is read only; writes change nothing.
// RULE12: begin select 1 is begin trace, 0 is end trace.
// RULE13: flags and count hold after the run until the next start.
`timescale 1ns/100ps
module dbgrs_top
  import dbgrs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // capture logic
  input wire logic i_match_a,
  input wire logic i_match_b,
  input wire logic i_trigger,
  input wire logic i_fifo_full,
  input wire logic [3:0] i_fifo_count,
  output logic o_debug_module_enable,
  output logic o_armed,
  output logic o_begin_trace,
  output logic o_run_start,
  output logic o_run_end,
  output logic o_irq
);
  // ==========================================================
  // state
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_wait;
    logic [7:0] rd_addr;
    logic [31:0] rdata;
    logic enable;
    logic begin_sel;
    logic [DBGRS_IRQ_W-1:0] irq_stat;
    logic [DBGRS_IRQ_W-1:0] irq_mask;
  } dbgrs_bus_s;

  dbgrs_bus_s state;
  dbgrs_bus_s next_state;

  dbgrs_run_if run ();

  logic addr_ok;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic new_en;
  logic new_arm;
  logic new_begin;
  logic [7:0] status_byte;
  logic [7:0] ctrl_byte;
  logic [DBGRS_IRQ_W-1:0] irq_set;
  logic [DBGRS_IRQ_W-1:0] irq_clr;
  logic [31:0] read_mux;

  // ==========================================================
  // run core
  dbgrs_run_core u_core (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .run(run.core)
  );

  assign run.match_a = i_match_a;
  assign run.match_b = i_match_b;
  assign run.trigger = i_trigger;
  assign run.fifo_full = i_fifo_full;
  assign run.fifo_count = i_fifo_count;
  assign run.begin_trace = state.begin_sel; // RULE12

  // ==========================================================
  // address phase
  always_comb begin
    addr_ok = i_hsel && (i_htrans == DBGRS_HTRANS_NONSEQ) && i_hready;
  end

  // ==========================================================
  // data phase write decode
  always_comb begin
    wr_ctrl = state.wr_pend && (state.wr_addr == DBGRS_OFS_CTRL);
    wr_stat = state.wr_pend && (state.wr_addr == DBGRS_OFS_IRQ_STAT);
    wr_mask = state.wr_pend && (state.wr_addr == DBGRS_OFS_IRQ_MASK);
    new_en = i_hwdata[DBGRS_CTRL_ENABLE];
    new_arm = i_hwdata[DBGRS_CTRL_ARM];
    new_begin = i_hwdata[DBGRS_CTRL_BEGIN];
  end

  // ==========================================================
  // run start and manual stop
  always_comb begin
    run.start = wr_ctrl && new_en && new_arm && !run.armed; // RULE4
    run.stop = wr_ctrl && run.armed && (!new_en || !new_arm); // RULE6
  end

  // ==========================================================
  // register images
  always_comb begin
    status_byte = 8'h00;
    status_byte[DBGRS_ST_MATCH_A] = run.match_a_flag;
    status_byte[DBGRS_ST_MATCH_B] = run.match_b_flag;
    status_byte[DBGRS_ST_ARMED] = run.armed && state.enable; // RULE3
    status_byte[DBGRS_ST_CNT_LSB +: DBGRS_CNT_W] = run.fifo_valid_count; // RULE8
    ctrl_byte = 8'h00;
    ctrl_byte[DBGRS_CTRL_ENABLE] = state.enable;
    ctrl_byte[DBGRS_CTRL_ARM] = run.armed; // RULE3
    ctrl_byte[DBGRS_CTRL_BEGIN] = state.begin_sel;
  end

  // ==========================================================
  // read mux, unmapped reads as zero
  always_comb begin
    case (state.rd_addr)
      DBGRS_OFS_CTRL: begin
        read_mux = {24'h00_0000, ctrl_byte};
      end
      DBGRS_OFS_STATUS: begin
        read_mux = {24'h00_0000, status_byte};
      end
      DBGRS_OFS_IRQ_STAT: begin
        read_mux = {29'h0000_0000, state.irq_stat};
      end
      DBGRS_OFS_IRQ_MASK: begin
        read_mux = {29'h0000_0000, state.irq_mask};
      end
      default: begin
        read_mux = DBGRS_RDATA_RESET;
      end
    endcase
  end

  // ==========================================================
  // interrupt events, set wins over clear
  always_comb begin
    irq_set = '0;
    irq_set[DBGRS_IRQ_RUN_END] = run.run_end;
    irq_set[DBGRS_IRQ_MATCH_A] = run.set_a;
    irq_set[DBGRS_IRQ_MATCH_B] = run.set_b;
    irq_clr = wr_stat ? i_hwdata[DBGRS_IRQ_W-1:0] : '0;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    // bus pipeline
    next_state.wr_pend = 1'b0;
    if (state.rd_wait) begin
      // read data loaded after any write ahead of it has landed
      next_state.rd_wait = 1'b0;
      next_state.rdata = read_mux;
    end
    if (addr_ok) begin
      if (i_hwrite) begin
        next_state.wr_pend = 1'b1;
        next_state.wr_addr = {i_haddr[7:2], 2'b00};
      end else begin
        next_state.rd_wait = 1'b1;
        next_state.rd_addr = {i_haddr[7:2], 2'b00};
      end
    end
    // control register
    if (wr_ctrl) begin
      next_state.enable = new_en;
      // mode is frozen while a run is in progress
      if (!run.armed) begin
        next_state.begin_sel = new_begin; // RULE12
      end
    end
    // status register is read only: a write there is dropped
    // RULE11
    if (wr_mask) begin
      next_state.irq_mask = i_hwdata[DBGRS_IRQ_W-1:0];
    end
    next_state.irq_stat = (state.irq_stat & ~irq_clr) | irq_set;
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state.wr_pend <= 1'b0;
      state.wr_addr <= 8'h00;
      state.rd_wait <= 1'b0;
      state.rd_addr <= 8'h00;
      state.rdata <= DBGRS_RDATA_RESET;
      state.enable <= 1'b0;
      state.begin_sel <= 1'b0;
      state.irq_stat <= DBGRS_IRQ_RESET;
      state.irq_mask <= DBGRS_IRQ_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign o_hrdata = state.rdata;
  assign o_hreadyout = !state.rd_wait;
  assign o_hresp = DBGRS_HRESP_OKAY;
  assign o_debug_module_enable = state.enable;
  assign o_armed = run.armed;
  assign o_begin_trace = state.begin_sel;
  assign o_run_start = run.run_start;
  assign o_run_end = run.run_end;
  assign o_irq = |(state.irq_stat & state.irq_mask);

  // hsize is not checked: only whole-word transfers are supported
  logic unused_hsize;
  assign unused_hsize = ^i_hsize;
endmodule : dbgrs_top

/* File: dbgrs_top_tb.sv */
// Purpose: register level tests of dbgrs_top
// Assumes: hready looped back from hreadyout
// Notes: capture side driven by the bench
`timescale 1ns/100ps
module dbgrs_top_tb;
  import dbgrs_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic hsel = 0, hwrite = 0, ma = 0, mb = 0, trig = 0, full = 0, load = 0, pop = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [3:0] fcnt = 4'h0, tally;
  logic hrdy, hresp, en, armed, bgn, rs, re, irq;
  int num_errors = 0;
  int n_checks = 0;
  always #5 i_clock = ~i_clock;
  dbgrs_top dbgrs_top_inst (.i_clock(i_clock), .i_reset(i_reset), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
    .o_hresp(hresp), .i_match_a(ma), .i_match_b(mb), .i_trigger(trig),
    .i_fifo_full(full), .i_fifo_count(fcnt), .o_debug_module_enable(en),
    .o_armed(armed), .o_begin_trace(bgn), .o_run_start(rs), .o_run_end(re), .o_irq(irq));
  dbgrs_host_model dbgrs_host_model_inst (.i_clock(i_clock), .i_load(load),
    .i_count(q[3:0]), .i_pop(pop), .o_tally(tally));
  // ==========================================================
  // tasks
  task final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick
  // waits for hready as long as it takes; only the watchdog ends a hang
  task wait_rdy;
    do begin
      @(posedge i_clock);
    end while (hrdy !== 1'b1);
  endtask : wait_rdy
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= DBGRS_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : xfer
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp, "read");
  endtask : rchk
  // ==========================================================
  // tests
  initial begin
    repeat (3000) @(posedge i_clock);
    num_errors++;
    final_report();
  end
  initial begin
    tick(12);
    i_reset <= 1'b0;
    xfer(1'b1, DBGRS_OFS_IRQ_MASK, 32'h1);
    rchk(DBGRS_OFS_STATUS, 32'h0);
    // end trace run with a match
    xfer(1'b1, DBGRS_OFS_CTRL, 32'hc0);
    ma <= 1'b1;
    fcnt <= 4'h3;
    tick(1);
    chk(rs, 1'b1, "run_start");
    ma <= 1'b0;
    rchk(DBGRS_OFS_STATUS, 32'ha3);
    trig <= 1'b1;
    tick(1);
    trig <= 1'b0;
    tick(1);
    chk(re, 1'b1, "run_end");
    tick(1);
    chk(irq, 1'b1, "irq");
    rchk(DBGRS_OFS_STATUS, 32'h83);
    xfer(1'b1, DBGRS_OFS_STATUS, 32'hff);
    rchk(DBGRS_OFS_STATUS, 32'h83);
    // host drains the fifo
    load <= 1'b1;
    tick(1);
    load <= 1'b0;
    pop <= 1'b1;
    fcnt <= 4'h0;
    mb <= 1'b1;
    tick(3);
    pop <= 1'b0;
    mb <= 1'b0;
    tick(1);
    chk(tally, 4'h0, "tally");
    rchk(DBGRS_OFS_STATUS, 32'h83);
    rchk(DBGRS_OFS_IRQ_STAT, 32'h3);
    xfer(1'b1, DBGRS_OFS_IRQ_STAT, 32'h7);
    tick(1);
    chk(irq, 1'b0, "irq");
    // begin trace run ends on full fifo
    xfer(1'b1, DBGRS_OFS_CTRL, 32'he0);
    rchk(DBGRS_OFS_STATUS, 32'h20);
    chk(bgn, 1'b1, "begin_trace");
    chk(hresp, DBGRS_HRESP_OKAY, "hresp");
    trig <= 1'b1;
    mb <= 1'b1;
    tick(1);
    trig <= 1'b0;
    mb <= 1'b0;
    rchk(DBGRS_OFS_STATUS, 32'h60);
    fcnt <= 4'h8;
    full <= 1'b1;
    tick(1);
    full <= 1'b0;
    fcnt <= 4'h0;
    tick(1);
    rchk(DBGRS_OFS_STATUS, 32'h48);
    // manual stops
    xfer(1'b1, DBGRS_OFS_CTRL, 32'hc0);
    xfer(1'b1, DBGRS_OFS_CTRL, 32'h80);
    rchk(DBGRS_OFS_STATUS, 32'h0);
    xfer(1'b1, DBGRS_OFS_CTRL, 32'hc0);
    xfer(1'b1, DBGRS_OFS_CTRL, 32'h40);
    tick(1);
    chk(armed, 1'b0, "armed");
    chk(en, 1'b0, "enable");
    rchk(DBGRS_OFS_STATUS, 32'h0);
    rchk(8'h10, 32'h0);
    final_report();
  end
endmodule : dbgrs_top_tb
